/* rtl/slw_pkg.sv */
// package of constants for the serial register load and lo direction block
// =============================================================================
package slw_pkg;
	localparam int WORD_W      = 24;
	localparam int CTRL_W      = 3;
	localparam int NUM_REGS    = 8;
	localparam int CTRL_LSB    = 0;
	localparam int LO_REG_IDX  = 5;   // register holding drive and external bits
	localparam int LO_DIV_REG  = 7;   // register holding output divider field
	localparam int DRV_BIT     = 3;
	localparam int EXT_BIT     = 4;
	localparam int DIV_LSB     = 3;   // divider field position in register 7
	localparam int DIV_W       = 2;
	localparam logic [WORD_W-1:0] REG_RST = 24'h000000;
	localparam int SCLK_MAX_MHZ = 20;
	localparam int SYS_MHZ      = 40;
endpackage : slw_pkg

/* rtl/slw_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/10ps
module slw_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// first stage only feeds second stage
	always_comb begin
		next_meta = d_i;
		next_q    = meta;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= next_meta;
			q_o  <= next_q;
		end
	end
endmodule : slw_sync

/* rtl/slw_top.sv */
// serial write port, configuration registers and lo port direction logic
`timescale 1ns/10ps
module slw_top (
	input  wire logic                       clk_sys_i,
	input  wire logic                       rstn_i,
	input  wire logic                       sclk_i,
	input  wire logic                       sdata_i,
	input  wire logic                       load_strobe_i,
	input  wire logic                       lo_direction_select_pin_i,
	output logic [slw_pkg::WORD_W-1:0]      cfg_word_o,
	output logic [slw_pkg::CTRL_W-1:0]      cfg_addr_o,
	output logic                            cfg_load_o,
	output logic                            lo_port_output_o,
	output logic                            lo_port_input_o,
	output logic [slw_pkg::DIV_W-1:0]       lo_out_div_o
);
	import slw_pkg::*;

	// =========================================================================
	// link side: shift register on serial clock
	// =========================================================================
	logic [WORD_W-1:0] shreg;
	logic [WORD_W-1:0] next_shreg;

	// msb arrives first, so shift toward msb
	always_comb begin
		next_shreg = {shreg[WORD_W-2:0], sdata_i};
	end

	// no reset: the serial clock stands still outside frames
	always_ff @(posedge sclk_i) begin
		shreg <= next_shreg;
	end

	// =========================================================================
	// crossing: strobe is synchronised, word is stable while strobe is high
	// =========================================================================
	logic le_s;
	logic le_d;
	logic next_le_d;
	logic [WORD_W-1:0] word_s1;
	logic [WORD_W-1:0] word_s2;
	logic [WORD_W-1:0] next_word_s1;
	logic [WORD_W-1:0] next_word_s2;

	slw_sync #(.W(1)) u_le_sync (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.d_i       (load_strobe_i),
		.q_o       (le_s)
	);

	// word is quiet once host raised strobe so two stages settle it
	always_comb begin
		next_word_s1 = shreg;
		next_word_s2 = word_s1;
		next_le_d    = le_s;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			word_s1 <= REG_RST;
			word_s2 <= REG_RST;
			le_d    <= 1'b0;
		end else begin
			word_s1 <= next_word_s1;
			word_s2 <= next_word_s2;
			le_d    <= next_le_d;
		end
	end

	logic le_rise;
	assign le_rise = le_s & ~le_d;

	// =========================================================================
	// configuration register file
	// =========================================================================
	logic [WORD_W-1:0] cfg_regs [NUM_REGS];
	logic [WORD_W-1:0] next_cfg_regs [NUM_REGS];
	logic [CTRL_W-1:0] dest;

	// control code in the low bits selects destination
	assign dest = word_s2[CTRL_LSB +: CTRL_W];

	// copy only on strobe rise; hold otherwise
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			next_cfg_regs[i] = cfg_regs[i];
		end
		if (le_rise) begin
			next_cfg_regs[dest] = word_s2;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				cfg_regs[i] <= REG_RST;
			end
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				cfg_regs[i] <= next_cfg_regs[i];
			end
		end
	end

	// =========================================================================
	// lo direction and outputs
	// =========================================================================
	logic sel_s;

	// select pin normally tied low, still synchronised
	slw_sync #(.W(1)) u_sel_sync (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.d_i       (lo_direction_select_pin_i),
		.q_o       (sel_s)
	);

	logic lo_output_drive_bit;
	logic external_lo_input_bit;
	logic next_out;
	logic next_in;
	logic [DIV_W-1:0] next_div;
	logic [WORD_W-1:0] next_word;
	logic [CTRL_W-1:0] next_addr;

	assign lo_output_drive_bit   = cfg_regs[LO_REG_IDX][DRV_BIT];
	assign external_lo_input_bit = cfg_regs[LO_REG_IDX][EXT_BIT];

	// other bit mixes leave the port undriven and not an input
	always_comb begin
		// output when pin high or drive set, ext clear
		next_out  = sel_s | (lo_output_drive_bit & ~external_lo_input_bit);
		// input only when all three agree
		next_in   = ~sel_s & ~lo_output_drive_bit & external_lo_input_bit;
		// divider from register 7 while output
		next_div  = next_out ? cfg_regs[LO_DIV_REG][DIV_LSB +: DIV_W] : '0;
		next_word = le_rise ? word_s2 : cfg_word_o;
		next_addr = le_rise ? dest : cfg_addr_o;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			lo_port_output_o <= 1'b0;
			lo_port_input_o  <= 1'b0;
			lo_out_div_o     <= '0;
			cfg_word_o       <= REG_RST;
			cfg_addr_o       <= '0;
			cfg_load_o       <= 1'b0;
		end else begin
			lo_port_output_o <= next_out;
			lo_port_input_o  <= next_in;
			lo_out_div_o     <= next_div;
			cfg_word_o       <= next_word;
			cfg_addr_o       <= next_addr;
			cfg_load_o       <= le_rise;
		end
	end

	// =========================================================================
	// assertions
	// =========================================================================
	property p_load_updates;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		le_rise |=> (cfg_regs[$past(dest)] == $past(word_s2)) && cfg_load_o;
	endproperty
	a_load_updates: assert property (p_load_updates) else $error("load lost");

	property p_hold;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		!le_rise |=> $stable(cfg_regs[LO_REG_IDX]) && !cfg_load_o;
	endproperty
	a_hold: assert property (p_hold) else $error("register changed w/o load");

	property p_dest;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		le_rise |=> cfg_addr_o == $past(word_s2[CTRL_W-1:0]);
	endproperty
	a_dest: assert property (p_dest) else $error("wrong destination");

	property p_lo_in;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(!sel_s && !lo_output_drive_bit && external_lo_input_bit) |=> lo_port_input_o;
	endproperty
	a_lo_in: assert property (p_lo_in) else $error("lo not input");

	property p_lo_out;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(sel_s || (lo_output_drive_bit && !external_lo_input_bit))
			|=> lo_port_output_o && !lo_port_input_o;
	endproperty
	a_lo_out: assert property (p_lo_out) else $error("lo not output");

	property p_div;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		lo_port_output_o |-> lo_out_div_o == $past(cfg_regs[LO_DIV_REG][DIV_LSB +: DIV_W]);
	endproperty
	a_div: assert property (p_div) else $error("divider mismatch");

	property p_exclusive;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		!(lo_port_output_o && lo_port_input_o);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("lo both ways");

	property p_shift;
		@(posedge sclk_i) 1'b1 |=> shreg[0] == $past(sdata_i);
	endproperty
	a_shift: assert property (p_shift) else $error("shift missed");

	property p_msb;
		// case equality: the unreset shift register is unknown until 24 bits are in
		@(posedge sclk_i) 1'b1 |=> shreg[WORD_W-1:1] === $past(shreg[WORD_W-2:0]);
	endproperty
	a_msb: assert property (p_msb) else $error("msb order broken");

	c_load: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) le_rise);
	c_load7: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
		le_rise && dest == CTRL_W'(LO_DIV_REG));
	c_in: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) lo_port_input_o);
	c_out: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) lo_port_output_o);
endmodule : slw_top

/* testbench/slw_host.sv */
// host controller model driving the three-wire serial write port
`timescale 1ns/10ps
module slw_host (
	output logic sclk_o,
	output logic sdata_o,
	output logic load_strobe_o
);
	import slw_pkg::*;
	// half period at the fastest legal serial rate, a 50 ns cycle
	localparam int HALF_NS = 500 / SCLK_MAX_MHZ;
	// serial clock stands low between frames
	initial begin
		sclk_o = 1'b0;
		sdata_o = 1'b0;
		load_strobe_o = 1'b0;
	end
	// =====================================
	// frame tasks
	// msb first, never faster than the serial limit
	task automatic shift(input logic [WORD_W-1:0] w);
		for (int i = WORD_W-1; i >= 0; i--) begin
			sdata_o = w[i];
			#(HALF_NS) sclk_o = 1'b1;
			#(HALF_NS) sclk_o = 1'b0;
		end
		sdata_o = ~sdata_o; // line driven to the inverse of the last bit, no stale bit
	endtask : shift
	// strobe only after a full word, gaps over 75 ns
	task automatic load();
		#100 load_strobe_o = 1'b1;
		#100 load_strobe_o = 1'b0;
		#100;
	endtask : load
endmodule : slw_host

/* testbench/testbench.sv */
// self-checking bench for the serial load and lo direction block
`timescale 1ns/10ps
module testbench;
	import slw_pkg::*;
	logic clk_sys_i, rstn_i, pin, ld, lo_o, lo_in;
	logic [WORD_W-1:0] word, regs [NUM_REGS], last;
	logic [CTRL_W-1:0] addr;
	logic [DIV_W-1:0] div;
	wire sclk, sdata, le;
	int fail_count = 0, compares = 0, seed = 32'h9dc293f5;
	slw_host host (.sclk_o(sclk), .sdata_o(sdata), .load_strobe_o(le));
	slw_top dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sclk_i(sclk), .sdata_i(sdata),
		.load_strobe_i(le), .lo_direction_select_pin_i(pin), .cfg_word_o(word),
		.cfg_addr_o(addr), .cfg_load_o(ld), .lo_port_output_o(lo_o),
		.lo_port_input_o(lo_in), .lo_out_div_o(div));
	// =====================================
	// helpers
	task end_of_test();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t %s got=%h exp=%h", $time, n, got, exp);
		end
	endtask : chk
	// model of the lo port direction, checked once settled
	task check_lo();
		logic o, i;
		logic [WORD_W-1:0] r5, r7;
		r5 = regs[LO_REG_IDX];
		r7 = regs[LO_DIV_REG];
		repeat (5) @(posedge clk_sys_i);
		#1;
		o = pin | (r5[DRV_BIT] & ~r5[EXT_BIT]);
		i = ~pin & ~r5[DRV_BIT] & r5[EXT_BIT];
		chk("out", lo_o, o);
		chk("in", lo_in, i);
		chk("div", div, o ? r7[DIV_LSB+:DIV_W] : 2'h0);
	endtask : check_lo
	task write(input logic [WORD_W-1:0] w);
		int n;
		host.shift(w);
		fork
			host.load();
			begin
				for (n = 0; n < 20; n++) begin
					@(posedge clk_sys_i);
					#1;
					if (ld === 1'b1) break;
				end
				if (n == 20) begin
					fail_count++;
					end_of_test();
				end
				chk("word", word, w);
				chk("addr", addr, w[2:0]);
				// load pulse stands for one cycle only
				@(posedge clk_sys_i);
				#1;
				chk("pulse", ld, 1'b0);
			end
		join
		regs[w[2:0]] = w;
		last = w;
		check_lo();
	endtask : write
	task reset_chk();
		@(posedge clk_sys_i);
		#2 rstn_i = 1'b0;
		repeat (6) @(posedge clk_sys_i);
		#2 rstn_i = 1'b1;
		foreach (regs[k]) regs[k] = REG_RST;
		chk("rst", word, REG_RST);
		chk("rst_addr", addr, 3'h0);
		chk("rst_ld", ld, 1'b0);
		check_lo();
	endtask : reset_chk
	initial begin
		clk_sys_i = 1'b0;
		forever #(500.0 / SYS_MHZ) clk_sys_i = ~clk_sys_i;
	end
	// =====================================
	// main sequence
	initial begin
		logic [WORD_W-1:0] w;
		pin = 1'b0;
		rstn_i = 1'b0;
		reset_chk();
		// every drive and external combination, pin both levels
		for (int k = 0; k < 8; k++) begin
			w = WORD_W'($random(seed));
			w[2:0] = 3'h7;
			write(w);
			w = WORD_W'($random(seed));
			w[2:0] = 3'h5;
			w[EXT_BIT] = k[1];
			w[DRV_BIT] = k[0];
			@(posedge clk_sys_i);
			#2 pin = k[2];
			write(w);
		end
		$display("test lo_modes done");
		// successive loads over every control code, each code twice, with a full shift and lo check between them
		for (int k = 0; k < 16; k++) begin
			w = WORD_W'($random(seed));
			w[2:0] = k[2:0];
			@(posedge clk_sys_i);
			#2 pin = 1'($random(seed));
			write(w);
		end
		$display("test codes done");
		// shifting with the strobe low must not disturb anything
		host.shift(WORD_W'($random(seed)));
		repeat (10) @(posedge clk_sys_i);
		#1;
		chk("hold", word, last);
		chk("hold_addr", addr, last[2:0]);
		chk("hold_ld", ld, 1'b0);
		check_lo();
		$display("test no_strobe done");
		reset_chk();
		$display("test reset done");
		end_of_test();
	end
endmodule : testbench
